// File: verilog/vic_top.sv
// Vectored interrupt controller: flags, enables, priorities, arbitration, vector output
//
// How it works
// - Sits beside the core, arbitrates pending events, passes only the winner.
// - Up to 76 sources on up to 46 vectors, sparse numbering.
// - Request n flag and enable at word n/32, bit n%32.
// - Per vector 3-bit priority, 2-bit subpriority, four vectors per word.
// - Seven software priority levels compared by the arbiter.
// - Four subpriority levels order vectors within one priority level.
// - Ties go to the lower request number; core timer ranks highest.
// - Capture error and capture event share one vector and priority pair.
// - Serial interface fault, receive, transfer share one vector and fields.
// - Two-wire collision, slave, master events share one vector and fields.
// - Capture, converter, USB, serial, UART, two-wire are persistent levels.
// - Timer, software, external, compare, clock-fail and others are edge events.
// - Single-vector mode uses one vector; multi-vector mode uses per-source vectors.
// - Five external pins, each with selectable edge polarity.
// - Two core software interrupts at requests 1 and 2.
// - Software may set any flag; it acts like a hardware request.
// - Vector table base is programmable; addresses are relative to it.
// - Vector spacing is programmable and applied to each vector address.
// - No shadow register set selection is given to the core.
`timescale 1ns/1ps
`default_nettype none
module vic_top
  import vic_pkg::*;
#(
  parameter int SPACING_W = 16
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   core_timer_request,
  input  wire logic                   core_soft_request_zero,
  input  wire logic                   core_soft_request_one,
  input  wire logic [EXT_NUM-1:0]     external_pin_request,
  input  wire logic [EXT_NUM-1:0]     ext_edge_rising,
  input  wire logic [IRQ_NUM-1:0]     periph_request,
  input  wire flag_words_t            flag_set_words,
  input  wire flag_words_t            flag_clr_words,
  input  wire flag_words_t            irq_enable_words,
  input  wire prio_words_t            irq_priority_control,
  input  wire logic                   multi_vector_en,
  input  wire logic [31:0]            vector_base,
  input  wire logic [SPACING_W-1:0]   vector_spacing,
  output flag_words_t                 irq_flag_status,
  output core_req_t                   core_req
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Priority and subpriority of a vector, used by every request
  function automatic logic [4:0] vec_score(input prio_words_t w, input logic [VEC_W-1:0] v);
    logic [31:0] word;
    int          base;
    word = w[v >> 2];
    base = int'(v[1:0]) * SLOT_STRIDE;
    return {word[base + PRIO_LSB +: 3], word[base + SUB_LSB +: 2]};
  endfunction : vec_score

  // Table address of a vector
  function automatic logic [31:0] vec_addr(input logic [31:0] b, input logic [VEC_W-1:0] v,
                                           input logic [SPACING_W-1:0] s);
    logic [31:0] prod;
    prod = 32'(v) * 32'(s);
    return b + prod;
  endfunction : vec_addr

  // ----------------------------------------
  // External pin synchronisers
  // ----------------------------------------
  logic [EXT_NUM-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
  logic [EXT_NUM-1:0] ext_lvl_d, ext_event;

  // Level only moves once the second and third stages agree
  always_comb begin
    ext_lvl_d = ext_lvl_q;
    for (int p = 0; p < EXT_NUM; p++) begin
      if (ext_s2_q[p] == ext_s3_q[p]) ext_lvl_d[p] = ext_s3_q[p];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_s1_q  <= '0;
      ext_s2_q  <= '0;
      ext_s3_q  <= '0;
      ext_lvl_q <= '0;
    end else begin
      ext_s1_q  <= external_pin_request;
      ext_s2_q  <= ext_s1_q;
      ext_s3_q  <= ext_s2_q;
      ext_lvl_q <= ext_lvl_d;
    end
  end

  // Edge of the chosen polarity on the filtered level
  always_comb begin
    for (int p = 0; p < EXT_NUM; p++) begin
      ext_event[p] = (ext_lvl_d[p] != ext_lvl_q[p]) &&
                     (ext_lvl_d[p] == ext_edge_rising[p]);
    end
  end

  // ----------------------------------------
  // Source collection
  // ----------------------------------------
  logic [IRQ_NUM-1:0] src, src_prev_q, src_prev_d, hw_set;

  // Core timer and software requests take fixed slots; pins override peripherals
  always_comb begin
    src = periph_request;
    src[CORE_TIMER_IRQ] = core_timer_request;
    src[SOFT_ZERO_IRQ]  = core_soft_request_zero;
    src[SOFT_ONE_IRQ]   = core_soft_request_one;
    for (int p = 0; p < EXT_NUM; p++) src[EXT_IRQ[p]] = 1'b0;
  end

  // Level sources re-raise while held; event sources raise once per rise, pins once per edge of the chosen polarity
  always_comb begin
    src_prev_d = src;
    for (int i = 0; i < IRQ_NUM; i++) begin
      if (irq_persistent(i)) hw_set[i] = src[i];
      else                   hw_set[i] = src[i] & ~src_prev_q[i];
    end
    for (int p = 0; p < EXT_NUM; p++) hw_set[EXT_IRQ[p]] = ext_event[p];
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  logic [FLAG_WORDS*32-1:0] flag_q, flag_d, sw_set, sw_clr, en_bits;

  assign sw_set  = flag_set_words;
  assign sw_clr  = flag_clr_words;
  assign en_bits = irq_enable_words;

  // Any set wins over a clear in the same cycle; unused high bits stay zero
  always_comb begin
    flag_d = (flag_q & ~sw_clr) | sw_set;
    flag_d[IRQ_NUM-1:0] = flag_d[IRQ_NUM-1:0] | hw_set;
    flag_d[FLAG_WORDS*32-1:IRQ_NUM] = '0;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q     <= FLAG_RESET;
      src_prev_q <= '0;
    end else begin
      flag_q     <= flag_d;
      src_prev_q <= src_prev_d;
    end
  end

  assign irq_flag_status = flag_q;

  // ----------------------------------------
  // Eligibility and scores
  // ----------------------------------------
  logic [IRQ_NUM-1:0]      eligible;
  logic [IRQ_NUM-1:0][4:0] score;

  // Shared vectors read one field pair, so grouped sources rank alike
  always_comb begin
    for (int i = 0; i < IRQ_NUM; i++) begin
      score[i]    = vec_score(irq_priority_control, irq_vector(i));
      eligible[i] = flag_q[i] && en_bits[i] && (score[i][4:2] != 3'h0);
    end
  end

  logic             win_valid;
  logic [IRQ_W-1:0] win_irq;
  logic [4:0]       win_score;

  vic_arbiter #(
    .N (IRQ_NUM)
  ) u_arb (
    .eligible  (eligible),
    .score     (score),
    .win_valid (win_valid),
    .win_irq   (win_irq),
    .win_score (win_score)
  );

  // ----------------------------------------
  // Request to the core
  // ----------------------------------------
  core_req_t        req_q, req_d;
  logic [VEC_W-1:0] win_vec;

  // Idle request reads all zero, so the core never sees a stale address
  // Vector, address, level, subpriority and request number go out; no register set select exists
  always_comb begin
    req_d   = '0;
    win_vec = multi_vector_en ? irq_vector(int'(win_irq)) : SINGLE_VECTOR;
    if (win_valid) begin
      req_d.valid  = 1'b1;
      req_d.level  = win_score[4:2];
      req_d.sub    = win_score[1:0];
      req_d.irq    = win_irq;
      req_d.vector = win_vec;
      req_d.addr   = vec_addr(vector_base, win_vec, vector_spacing);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) req_q <= '0;
    else         req_q <= req_d;
  end

  assign core_req = req_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [2:0] soft_flag_age;
  always_ff @(posedge clk) begin
    if (sys_rst) soft_flag_age <= '0;
    else         soft_flag_age <= {soft_flag_age[1:0], $rose(core_soft_request_zero)};
  end

  a_req_follows_win: assert property ($past(win_valid) == req_q.valid)
    else $error("core request does not follow arbitration");
  a_zero_prio_off: assert property (req_q.valid |-> req_q.level != 3'h0)
    else $error("priority zero request reached the core");
  a_idle_zero: assert property (
      !req_q.valid |-> req_q == '0)
    else $error("idle core request carries stale fields");

  // Flag set, clear and placement
  a_sw_set_wins: assert property (
      (flag_set_words[0][4] && flag_clr_words[0][4]) |=> irq_flag_status[0][4])
    else $error("software set lost to clear");
  a_clear_works: assert property (
      (flag_clr_words[0][7] && !flag_set_words[0][7] && !hw_set[7]) |=> !irq_flag_status[0][7])
    else $error("software clear did not drop the flag");
  a_word_one: assert property (
      flag_set_words[1][0] |=> irq_flag_status[1][0])
    else $error("request 32 not at bit 0 of word 1");
  a_flag_top_zero: assert property (
      irq_flag_status[2][31:20] == 12'h000)
    else $error("flag bits above the request space not zero");
  a_persist_holds: assert property (periph_request[28] |=> irq_flag_status[0][28])
    else $error("persistent flag dropped while source held");

  // Event sources raise once per edge
  a_event_once: assert property (
      (periph_request[29] && $past(periph_request[29]) && flag_clr_words[0][29]
       && !flag_set_words[0][29]) |=> !irq_flag_status[0][29])
    else $error("event source re-raised without a new edge");
  a_event_rise: assert property (
      $rose(periph_request[29]) |=> irq_flag_status[0][29])
    else $error("event source edge not flagged");
  a_timer_event: assert property (
      $rose(core_timer_request) |=> irq_flag_status[0][0])
    else $error("core timer edge not flagged");
  a_soft_flag: assert property (soft_flag_age[0] |-> irq_flag_status[0][1])
    else $error("software interrupt zero not flagged");
  a_soft_one: assert property (
      $rose(core_soft_request_one) |=> irq_flag_status[0][2])
    else $error("software interrupt one not flagged");
  a_pin_flag: assert property (
      ext_event[0] |=> irq_flag_status[0][3])
    else $error("pin zero edge not flagged");
  a_pin_fall: assert property (
      ext_event[2] |=> irq_flag_status[0][13])
    else $error("pin two edge not flagged");

  // Arbitration only picks flagged, enabled, nonzero requests
  a_win_flagged: assert property (
      win_valid |-> flag_q[win_irq])
    else $error("winner has no pending flag");
  a_win_enabled: assert property (
      win_valid |-> en_bits[win_irq])
    else $error("winner is not enabled");
  a_prio_zero_blocks: assert property (
      (flag_q[7] && en_bits[7] && score[7][4:2] == 3'h0) |-> !(win_valid && win_irq == 7'h07))
    else $error("priority zero request won arbitration");
  a_timer_first: assert property (
      (win_valid && eligible[0]) |-> (win_irq == 7'h00 || win_score > score[0]))
    else $error("core timer lost a tie");

  // Vector numbers in single- and multi-vector mode, and vector addresses
  a_single_vec: assert property (
      (req_q.valid && !$past(multi_vector_en)) |-> req_q.vector == SINGLE_VECTOR)
    else $error("single vector mode gave another vector");
  a_capture_share: assert property (
      (req_q.valid && req_q.irq == 7'h06 && $past(multi_vector_en)) |-> req_q.vector == 6'h05)
    else $error("capture event not on shared vector");
  a_err_share: assert property (
      (req_q.valid && req_q.irq == 7'h05 && $past(multi_vector_en)) |-> req_q.vector == 6'h05)
    else $error("capture error not on shared vector");
  a_spi_share: assert property (
      (req_q.valid && req_q.irq == 7'h25 && $past(multi_vector_en)) |-> req_q.vector == 6'h1E)
    else $error("serial transfer done not on shared vector");
  a_twowire_share: assert property (
      (req_q.valid && req_q.irq == 7'h2B && $past(multi_vector_en)) |-> req_q.vector == 6'h20)
    else $error("two-wire master not on shared vector");
  a_convert_vec: assert property (
      (req_q.valid && req_q.irq == 7'h1C && $past(multi_vector_en)) |-> req_q.vector == 6'h17)
    else $error("converter request on wrong vector");
  a_addr_form: assert property (
      req_q.valid |->
      req_q.addr == $past(vector_base) + 32'(req_q.vector) * 32'($past(vector_spacing)))
    else $error("vector address not base plus spacing times vector");

endmodule : vic_top
`default_nettype wire

// File: verilog/vic_pkg.sv
// Shared constants, types and lookup functions of the vectored interrupt controller
`default_nettype none
package vic_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int MAX_SOURCES = 76;   // Sources present on the largest part
  localparam int MAX_VECTORS = 46;   // Shared vectors on the largest part
  localparam int IRQ_NUM     = 84;   // Request number space, sparse
  localparam int VEC_NUM     = 50;   // Vector number space, sparse
  localparam int IRQ_W       = 7;
  localparam int VEC_W       = 6;
  localparam int FLAG_WORDS  = 3;    // Request n sits in word n/32, bit n%32
  localparam int PRIO_WORDS  = 13;   // Four vectors per priority word
  localparam int EXT_NUM     = 5;

  // ----------------------------------------
  // Field positions and fixed request numbers
  // ----------------------------------------
  localparam int SLOT_STRIDE = 8;    // Vector slots at 4:2/1:0, 12:10/9:8, ...
  localparam int PRIO_LSB    = 2;
  localparam int SUB_LSB     = 0;
  localparam int CORE_TIMER_IRQ = 0;
  localparam int SOFT_ZERO_IRQ  = 1;
  localparam int SOFT_ONE_IRQ   = 2;
  localparam logic [EXT_NUM-1:0][IRQ_W-1:0] EXT_IRQ = {7'h17, 7'h12, 7'h0D, 7'h08, 7'h03};
  localparam logic [FLAG_WORDS*32-1:0] FLAG_RESET = '0;
  localparam logic [VEC_W-1:0] SINGLE_VECTOR = 6'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [FLAG_WORDS-1:0][31:0] flag_words_t;
  typedef logic [PRIO_WORDS-1:0][31:0] prio_words_t;

  typedef struct packed {
    logic             valid;
    logic [2:0]       level;
    logic [1:0]       sub;
    logic [IRQ_W-1:0] irq;
    logic [VEC_W-1:0] vector;
    logic [31:0]      addr;
  } core_req_t;

  // ----------------------------------------
  // Request number to vector number
  // ----------------------------------------
  function automatic logic [VEC_W-1:0] irq_vector(input int n);
    int v;
    if (n <= 4) v = n;
    else if (n <= 28) v = 5 + ((n - 5) / 5) * 4 + (((n - 5) % 5 < 2) ? 0 : ((n - 5) % 5) - 1);
    else if (n <= 34) v = n - 5;
    else if (n <= 43) v = 30 + (n - 35) / 3;
    else if (n <= 50) v = 33;
    else if (n <= 52) v = 34;
    else if (n <= 70) v = 35 + (n - 53) / 3;
    else if (n <= 77) v = n - 30;
    else v = 48 + (n - 78) / 3;
    return v[VEC_W-1:0];
  endfunction : irq_vector

  // Level sources keep their flag up while the cause stands
  function automatic logic irq_persistent(input int n);
    logic p;
    p = 1'b0;
    if (n >= 5 && n <= 26 && ((n - 5) % 5 < 2)) p = 1'b1;
    if (n == 28 || (n >= 34 && n <= 71) || (n >= 77 && n <= 83)) p = 1'b1;
    return p;
  endfunction : irq_persistent

endpackage : vic_pkg
`default_nettype wire

// File: verilog/vic_arbiter.sv
// Priority arbiter: highest priority and subpriority wins, lower request number breaks ties
`timescale 1ns/1ps
`default_nettype none
module vic_arbiter
  import vic_pkg::*;
#(
  parameter int N = IRQ_NUM
) (
  input  wire logic [N-1:0]       eligible,
  input  wire logic [N-1:0][4:0]  score,
  output logic                    win_valid,
  output logic [IRQ_W-1:0]        win_irq,
  output logic [4:0]              win_score
);

  // ----------------------------------------
  // Linear scan from the top down
  // ----------------------------------------
  // Scanning downward with >= lets the lower number take over on a tie
  always_comb begin
    win_valid = 1'b0;
    win_irq   = '0;
    win_score = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (eligible[i] && (!win_valid || score[i] >= win_score)) begin
        win_valid = 1'b1;
        win_irq   = IRQ_W'(i);
        win_score = score[i];
      end
    end
  end

endmodule : vic_arbiter
`default_nettype wire

// File: sim/core_model.sv
// Core side model: takes the presented request and clears its flag after a delay
`timescale 1ns/1ps
`default_nettype none
module core_model
  import vic_pkg::*;
#(
  parameter int LAT = 2
) (
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire logic      service_en,
  input  wire core_req_t core_req,
  output flag_words_t    clr_words,
  output logic [7:0]     served
);
  logic [7:0]       wait_q;
  logic [IRQ_W-1:0] irq_q;

  // ------------------------------------
  // Service sequencing
  // ------------------------------------
  // Hold off two cycles after the clear so a stale winner is not taken twice
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_q <= 8'h00;
      irq_q  <= '0;
      served <= 8'h00;
    end else if (wait_q != 8'h00) begin
      wait_q <= wait_q - 8'h01;
    end else if (service_en && core_req.valid) begin
      wait_q <= 8'(LAT + 2);
      irq_q  <= core_req.irq;
      served <= served + 8'h01;
    end
  end

  // Handler clears the pending flag the way software does
  assign clr_words = (wait_q == 8'h03) ? flag_words_t'(96'h1 << irq_q) : '0;
endmodule : core_model
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking testbench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import vic_pkg::*;
  logic               clk;
  logic               sys_rst;
  logic               ct_req, cs0_req, cs1_req, multi_en, svc_en;
  logic [EXT_NUM-1:0] pins, rising;
  logic [IRQ_NUM-1:0] periph;
  flag_words_t        set_w, clr_w, en_w, status, svc_clr, clr_mix;
  prio_words_t        prio_w;
  logic [31:0]        base;
  logic [15:0]        spacing;
  core_req_t          req;
  core_req_t          exp_r;
  logic [7:0]         served;
  logic [95:0]        cmask = '0;
  logic [95:0]        exp_f;
  int failures = 0, samples_checked = 0, seed = 60, cycles = 0;
  // Candidates cover shared vectors, the core timer and word 1 bit 0
  int cand_irq[14] = '{0, 1, 2, 4, 5, 6, 7, 28, 29, 32, 35, 37, 41, 43};
  int cand_vec[14] = '{0, 1, 2, 4, 5, 5, 6, 23, 24, 27, 30, 30, 32, 32};

  // ------------------------------------
  // Clock, timeout, instances
  // ------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      stop_test();
    end
  end

  assign clr_mix = clr_w | svc_clr;

  vic_top u_dut (.clk(clk), .sys_rst(sys_rst), .core_timer_request(ct_req),
    .core_soft_request_zero(cs0_req), .core_soft_request_one(cs1_req),
    .external_pin_request(pins), .ext_edge_rising(rising), .periph_request(periph),
    .flag_set_words(set_w), .flag_clr_words(clr_mix), .irq_enable_words(en_w),
    .irq_priority_control(prio_w), .multi_vector_en(multi_en), .vector_base(base),
    .vector_spacing(spacing), .irq_flag_status(status), .core_req(req));

  core_model u_core (.clk(clk), .sys_rst(sys_rst), .service_en(svc_en),
    .core_req(req), .clr_words(svc_clr), .served(served));

  // ------------------------------------
  // Checking helpers
  // ------------------------------------
  // Highest level then sublevel wins; strict compare keeps the lower number on ties
  function automatic core_req_t expect_req(logic [95:0] f, logic [95:0] e, prio_words_t p);
    core_req_t  r;
    logic [4:0] sc;
    int         v;
    int         q;
    r = '0;
    for (int i = 0; i < 14; i++) begin
      q = cand_irq[i];
      v = cand_vec[i];
      sc = p[v / 4][8 * (v % 4) +: 5];
      if (f[q] && e[q] && sc[4:2] != 3'h0 && (!r.valid || sc > {r.level, r.sub})) begin
        r.valid = 1'b1;
        r.level = sc[4:2];
        r.sub = sc[1:0];
        r.irq = IRQ_W'(q);
        r.vector = VEC_W'(v);
        r.addr = base + 32'(v) * 32'(spacing);
      end
    end
    return r;
  endfunction : expect_req

  task automatic cmp_val(logic [95:0] got, logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_req(core_req_t got, core_req_t exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_req

  task automatic stop_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    int n;
    {ct_req, cs0_req, cs1_req, svc_en, periph, set_w, clr_w, en_w, prio_w} = '0;
    multi_en = 1'b1;
    pins = 5'b00100;
    rising = 5'b11011;
    base = 32'h0000_1000;
    spacing = 16'h0020;
    sys_rst = 1'b1;
    for (int i = 0; i < 14; i++) cmask[cand_irq[i]] = 1'b1;
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    cmp_req(req, '0);
    // Hardware sources; priority 0 everywhere so nothing may win
    en_w = '1;
    {ct_req, cs0_req, cs1_req} = 3'b111;
    periph[7] = 1'b1;
    periph[28] = 1'b1;
    periph[29] = 1'b1;
    @(negedge clk);
    cmp_val(status, 96'h3000_0087);
    clr_w = '1;
    @(negedge clk);
    cmp_val(status, 96'h1000_0000);
    cmp_req(req, '0);
    periph = '0;
    clr_w = '1;
    // Pin 0 rises, pin 2 falls: both polarities in one go
    @(negedge clk);
    clr_w = '0;
    pins = 5'b00001;
    n = 0;
    while (!(status[0][3] && status[0][13]) && n < 12) begin
      @(negedge clk);
      n++;
    end
    cmp_val(status, 96'h0000_2008);
    // Random rounds; every fourth round ties all vectors on one level
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      clr_w = '1;
      for (int w = 0; w < PRIO_WORDS; w++) begin
        prio_w[w] = (k % 4 == 0) ? 32'h0D0D_0D0D : $random(seed);
      end
      for (int w = 0; w < FLAG_WORDS; w++) en_w[w] = $random(seed) | $random(seed);
      base = $random(seed);
      spacing = 16'($random(seed));
      @(negedge clk);
      clr_w = '0;
      set_w = cmask & {$random(seed), $random(seed), $random(seed)};
      exp_f = set_w;
      @(negedge clk);
      set_w = '0;
      cmp_val(status, exp_f);
      @(negedge clk);
      exp_r = expect_req(exp_f, en_w, prio_w);
      cmp_req(req, exp_r);
    end
    // Single-vector mode: one vector, address at the base
    prio_w = {PRIO_WORDS{32'h1F1F_1F1F}};
    en_w = '1;
    multi_en = 1'b0;
    clr_w = '1;
    set_w = 96'h90;  // Bit 4 set and cleared in one cycle: set must win
    @(negedge clk);
    {clr_w, set_w} = '0;
    @(negedge clk);
    cmp_val(96'({req.valid, req.vector, req.addr}), 96'({1'b1, 6'h00, base}));
    // Core services three requests, each clearing its own flag
    multi_en = 1'b1;
    set_w = 96'h2000_0090;
    svc_en = 1'b1;
    @(negedge clk);
    set_w = '0;
    n = 0;
    while (status !== '0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    cmp_val(status, '0);
    cmp_val(96'(served), 96'h3);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
